// File: src/urx_pkg.sv
// package for the uart receive error / interrupt / wake block
// assumes a 125 MHz system clock and an apb master with 32-bit data
package urx_pkg;

   // ----------------------------------------
   // apb map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] URX_ADDR_STATUS = 12'h0000;
   localparam logic [11:0] URX_ADDR_CTRL_ONE = 12'h0004;
   localparam logic [11:0] URX_ADDR_CTRL_TWO = 12'h0008;
   localparam logic [11:0] URX_ADDR_DATA = 12'h000C;
   localparam logic [11:0] URX_ADDR_BAUD = 12'h0010;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int URX_ST_AVAIL = 0;
   localparam int URX_ST_OVERRUN = 1;
   localparam int URX_ST_NOISE = 2;
   localparam int URX_ST_FRAMING = 3;
   localparam int URX_ST_PARITY = 4;
   localparam int URX_ST_TX_EMPTY = 5;
   localparam int URX_ST_TX_IDLE = 6;

   localparam int URX_C1_NINE_BIT = 0;
   localparam int URX_C1_PARITY_EN = 1;
   localparam int URX_C1_PARITY_ODD = 2;
   localparam int URX_C1_TWO_STOP = 3;
   localparam int URX_C1_UNIT_EN = 4;
   localparam int URX_C1_RX_EN = 5;
   localparam int URX_C1_WIDTH = 6;

   localparam int URX_C2_RX_IRQ = 0;
   localparam int URX_C2_TXE_IRQ = 1;
   localparam int URX_C2_TXI_IRQ = 2;
   localparam int URX_C2_ADDR_EN = 3;
   localparam int URX_C2_WAKE_EN = 4;
   localparam int URX_C2_WIDTH = 5;

   localparam int URX_WORD_BITS = 9;
   localparam int URX_BAUD_BITS = 8;
   localparam int URX_TOP_NINE = 8;
   localparam int URX_TOP_EIGHT = 7;
   localparam logic [URX_WORD_BITS-1:0] URX_MASK_NINE = 9'h1FF;
   localparam logic [URX_WORD_BITS-1:0] URX_MASK_EIGHT = 9'h0FF;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [URX_C1_WIDTH-1:0] URX_C1_RESET = 6'h00;
   localparam logic [URX_C2_WIDTH-1:0] URX_C2_RESET = 5'h00;
   localparam logic [URX_BAUD_BITS-1:0] URX_BAUD_RESET = 8'h00;

   // frame as delivered by the oversampling core
   typedef struct packed {
      logic [URX_WORD_BITS-1:0] bits;
      logic parity_bit;
      logic stop_one;
      logic stop_two;
      logic noise;
   } urx_frame_t;

   // word as held in the receive buffer
   typedef struct packed {
      logic [URX_WORD_BITS-1:0] data;
      logic framing_err;
      logic parity_err;
   } urx_word_t;

   localparam int URX_WORD_W = URX_WORD_BITS + 2;

   // wake sequencing
   typedef enum logic [2:0] {
      URX_WK_RUN = 3'b001,
      URX_WK_ARMED = 3'b010,
      URX_WK_LATENCY = 3'b100
   } urx_wake_t;

endpackage

// File: src/urx_fifo.sv
// small flip-flop fifo used as the receive data buffer
// assumes push and pop are one-cycle strobes in the clk domain
`timescale 1ns/10ps
`default_nettype none
module urx_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic full,
   output logic empty
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] wr_ptr;
   logic [CW-1:0] count;
   wire do_push = push && !full;
   wire do_pop = pop && !empty;
   wire [PW-1:0] next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
   wire [PW-1:0] next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;

   assign head = mem[rd_ptr];
   assign full = (count == FULL_CNT);
   assign empty = (count == '0);

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= next_wr_ptr;
         end
         if (do_pop) begin
            rd_ptr <= next_rd_ptr;
         end
         count <= count + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule
`default_nettype wire

// File: src/urx_core.sv
// uart receive errors, interrupt request and rx wake-up, apb register slave
// assumes an oversampling core delivering whole frames and a cpu core
// reporting clock-off / running state; all inputs synchronous to CLK
//
// Function
// - buffer holds two words; a third completing while full sets overrun
// - on overrun keep buffered words, drop incoming; irq if rx irq enabled
// - overrun clears only after status access then data buffer read
// - noise flag sets with rx available; word still stored; no own irq
// - noise clears after status access then data buffer read
// - framing error when any expected stop bit is zero; stored with word
// - parity error when parity enabled and wrong; stored with word
// - interrupt request is a low pulse from six uart sources
// - each tx condition has own enable; rx sources share one enable
// - address detect raises irq with no flag, only when enabled
// - clock off with wake and rx irq enabled: rx fall raises irq
// - status flags read-only; writes and irq entry do not change them
// - address mode: rx available irq only when top received bit high
// - no address mode: rx available irq on every word
// - clock off pauses transfer; it resumes when clock returns
// - idle or sleep leaves status, controls, buffer and divisor unchanged
// - wake only if wake, unit, receiver and rx irq enables set at power down
// - rx data arriving during wake latency is ignored
// - wake irq needs global and uart enables, and waits for normal run
`timescale 1ns/10ps
`default_nettype none
module urx_core
   import urx_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic FRAME_DONE,
   input wire urx_frame_t FRAME,
   input wire logic TX_EMPTY,
   input wire logic TX_IDLE,
   input wire logic RX_PIN,
   input wire logic CLK_OFF,
   input wire logic CPU_RUNNING,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic UART_IRQ_ENABLE,
   output logic UART_IRQ_N,
   output logic WAKE_UP,
   output logic XFER_RUN,
   output logic NINE_BIT_SELECT,
   output logic TWO_STOP,
   output logic [URX_BAUD_BITS-1:0] BAUD_DIVISOR
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [URX_C1_WIDTH-1:0] uart_control_one;
   logic [URX_C2_WIDTH-1:0] uart_control_two;
   logic [URX_BAUD_BITS-1:0] baud_divisor_reg;
   logic overrun_flag;
   logic noise_flag;
   logic status_seen;
   logic tx_empty_q;
   logic tx_idle_q;
   logic rx_pin_q;
   logic wake_irq_due;
   urx_wake_t wake_state;
   urx_wake_t next_wake_state;

   // ----------------------------------------
   // control decode
   // ----------------------------------------
   wire nine_bit_select = uart_control_one[URX_C1_NINE_BIT];
   wire parity_enable = uart_control_one[URX_C1_PARITY_EN];
   wire parity_odd = uart_control_one[URX_C1_PARITY_ODD];
   wire two_stop = uart_control_one[URX_C1_TWO_STOP];
   wire uart_unit_enable = uart_control_one[URX_C1_UNIT_EN];
   wire receiver_enable = uart_control_one[URX_C1_RX_EN];
   wire rx_irq_enable = uart_control_two[URX_C2_RX_IRQ];
   wire tx_empty_irq_enable = uart_control_two[URX_C2_TXE_IRQ];
   wire tx_idle_irq_enable = uart_control_two[URX_C2_TXI_IRQ];
   wire address_detect_enable = uart_control_two[URX_C2_ADDR_EN];
   wire wake_enable = uart_control_two[URX_C2_WAKE_EN];

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire apb_done = PSEL && PENABLE && PREADY;
   wire apb_wr = apb_done && PWRITE;
   wire apb_rd = apb_done && !PWRITE;
   wire hit_status = (PADDR == URX_ADDR_STATUS);
   wire hit_ctrl_one = (PADDR == URX_ADDR_CTRL_ONE);
   wire hit_ctrl_two = (PADDR == URX_ADDR_CTRL_TWO);
   wire hit_data = (PADDR == URX_ADDR_DATA);
   wire hit_baud = (PADDR == URX_ADDR_BAUD);
   wire hit_any = hit_status || hit_ctrl_one || hit_ctrl_two || hit_data || hit_baud;
   wire status_access = apb_done && hit_status;
   wire data_read = apb_rd && hit_data;
   // clear pair: status access earlier, then data read
   wire clear_pair = data_read && status_seen;

   // ----------------------------------------
   // frame checks
   // ----------------------------------------
   wire [URX_WORD_BITS-1:0] word_mask = nine_bit_select ? URX_MASK_NINE : URX_MASK_EIGHT;
   wire [URX_WORD_BITS-1:0] word_bits = FRAME.bits & word_mask;
   wire ones_odd = ^{word_bits, FRAME.parity_bit};
   wire parity_bad = parity_enable && (ones_odd != parity_odd);
   wire stop_bad = !FRAME.stop_one || (two_stop && !FRAME.stop_two);
   wire top_bit = nine_bit_select ? FRAME.bits[URX_TOP_NINE] : FRAME.bits[URX_TOP_EIGHT];

   // words seen while waking up are dropped
   wire rx_live = (wake_state == URX_WK_RUN) && !CLK_OFF;
   wire frame_in = FRAME_DONE && rx_live && uart_unit_enable && receiver_enable;

   logic fifo_full;
   logic fifo_empty;
   urx_word_t head_word;
   urx_word_t new_word;
   logic [URX_WORD_W-1:0] head_raw;

   assign new_word.data = word_bits;
   assign new_word.framing_err = stop_bad;
   assign new_word.parity_err = parity_bad;
   assign head_word = urx_word_t'(head_raw);

   wire push = frame_in && !fifo_full;
   wire overrun_event = frame_in && fifo_full;
   wire pop = data_read && !fifo_empty;
   wire rx_available_flag = !fifo_empty;

   // ----------------------------------------
   // receive buffer
   // ----------------------------------------
   urx_fifo #(
      .WIDTH(URX_WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(CLK),
      .rst(SYS_RST),
      .push(push),
      .push_data(new_word),
      .pop(pop),
      .head(head_raw),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   // error bits follow the word at the head, so read status before data
   wire framing_error_flag = rx_available_flag && head_word.framing_err;
   wire parity_error_flag = rx_available_flag && head_word.parity_err;

   // ----------------------------------------
   // interrupt sources
   // ----------------------------------------
   wire tx_empty_rise = TX_EMPTY && !tx_empty_q;
   wire tx_idle_rise = TX_IDLE && !tx_idle_q;
   wire irq_tx = (tx_empty_rise && tx_empty_irq_enable)
      || (tx_idle_rise && tx_idle_irq_enable);
   // rx available qualified by the top bit in address mode
   wire irq_rx_avail = push && rx_irq_enable
      && (!address_detect_enable || top_bit);
   wire irq_overrun = overrun_event && rx_irq_enable;
   wire irq_addr = push && address_detect_enable && top_bit;
   wire irq_any = irq_tx || irq_rx_avail || irq_overrun || irq_addr
      || (wake_irq_due && CPU_RUNNING);

   // ----------------------------------------
   // wake-up sequencing
   // ----------------------------------------
   wire wake_arm_ok = wake_enable && uart_unit_enable && receiver_enable
      && rx_irq_enable;
   wire rx_fall = rx_pin_q && !RX_PIN;

   always_comb begin
      next_wake_state = wake_state;
      case (wake_state)
         URX_WK_RUN: begin
            if (CLK_OFF && wake_arm_ok) begin
               next_wake_state = URX_WK_ARMED;
            end
         end
         URX_WK_ARMED: begin
            if (!CLK_OFF) begin
               next_wake_state = URX_WK_RUN;
            end else if (rx_fall) begin
               next_wake_state = URX_WK_LATENCY;
            end
         end
         URX_WK_LATENCY: begin
            if (CPU_RUNNING && !CLK_OFF) begin
               next_wake_state = URX_WK_RUN;
            end
         end
         default: begin
            next_wake_state = URX_WK_RUN;
         end
      endcase
   end

   wire wake_fire = (wake_state == URX_WK_ARMED) && CLK_OFF && rx_fall;
   // interrupt only with both cpu enables, held until the cpu runs again
   wire wake_irq_arm = wake_fire && GLOBAL_IRQ_ENABLE && UART_IRQ_ENABLE;

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [31:0] status_word;
   logic [31:0] next_prdata;
   always_comb begin
      status_word = '0;
      status_word[URX_ST_AVAIL] = rx_available_flag;
      status_word[URX_ST_OVERRUN] = overrun_flag;
      status_word[URX_ST_NOISE] = noise_flag;
      status_word[URX_ST_FRAMING] = framing_error_flag;
      status_word[URX_ST_PARITY] = parity_error_flag;
      status_word[URX_ST_TX_EMPTY] = TX_EMPTY;
      status_word[URX_ST_TX_IDLE] = TX_IDLE;
      next_prdata = '0;
      if (hit_status) begin
         next_prdata = status_word;
      end else if (hit_ctrl_one) begin
         next_prdata[URX_C1_WIDTH-1:0] = uart_control_one;
      end else if (hit_ctrl_two) begin
         next_prdata[URX_C2_WIDTH-1:0] = uart_control_two;
      // empty buffer reads zero, never a stale slot
      end else if (hit_data && rx_available_flag) begin
         next_prdata[URX_WORD_BITS-1:0] = head_word.data;
      end else if (hit_baud) begin
         next_prdata[URX_BAUD_BITS-1:0] = baud_divisor_reg;
      end
   end

   // ----------------------------------------
   // apb slave: one wait state, data and error registered
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && PENABLE && !PREADY;
         PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? next_prdata : '0;
         PSLVERR <= PSEL && PENABLE && !PREADY && !hit_any;
      end
   end

   // status and data writes are ignored
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         uart_control_one <= URX_C1_RESET;
         uart_control_two <= URX_C2_RESET;
         baud_divisor_reg <= URX_BAUD_RESET;
      end else if (apb_wr) begin
         if (hit_ctrl_one) begin
            uart_control_one <= PWDATA[URX_C1_WIDTH-1:0];
         end
         if (hit_ctrl_two) begin
            uart_control_two <= PWDATA[URX_C2_WIDTH-1:0];
         end
         if (hit_baud) begin
            baud_divisor_reg <= PWDATA[URX_BAUD_BITS-1:0];
         end
      end
   end

   // ----------------------------------------
   // sticky flags: a new event wins over the clear
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         overrun_flag <= 1'b0;
         noise_flag <= 1'b0;
         status_seen <= 1'b0;
      end else begin
         if (overrun_event) begin
            overrun_flag <= 1'b1;
         end else if (clear_pair) begin
            overrun_flag <= 1'b0;
         end
         if (push && FRAME.noise) begin
            noise_flag <= 1'b1;
         end else if (clear_pair) begin
            noise_flag <= 1'b0;
         end
         if (status_access) begin
            status_seen <= 1'b1;
         end else if (data_read) begin
            status_seen <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // irq pulse, wake and edge history
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         UART_IRQ_N <= 1'b1;
         WAKE_UP <= 1'b0;
         XFER_RUN <= 1'b0;
         wake_state <= URX_WK_RUN;
         wake_irq_due <= 1'b0;
         tx_empty_q <= 1'b0;
         tx_idle_q <= 1'b0;
         rx_pin_q <= 1'b1;
      end else begin
         UART_IRQ_N <= !irq_any;
         WAKE_UP <= wake_fire;
         XFER_RUN <= !CLK_OFF;
         wake_state <= next_wake_state;
         if (wake_irq_arm) begin
            wake_irq_due <= 1'b1;
         end else if (CPU_RUNNING) begin
            wake_irq_due <= 1'b0;
         end
         tx_empty_q <= TX_EMPTY;
         tx_idle_q <= TX_IDLE;
         rx_pin_q <= RX_PIN;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         NINE_BIT_SELECT <= 1'b0;
         TWO_STOP <= 1'b0;
         BAUD_DIVISOR <= URX_BAUD_RESET;
      end else begin
         NINE_BIT_SELECT <= nine_bit_select;
         TWO_STOP <= two_stop;
         BAUD_DIVISOR <= baud_divisor_reg;
      end
   end
endmodule
`default_nettype wire

// File: tb/urx_monitor.sv
// checker on urx_core ports
// assumes sync active-high reset on CLK
`timescale 1ns/10ps
`default_nettype none
module urx_monitor
   import urx_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic PREADY,
   input wire logic RX_PIN,
   input wire logic CLK_OFF,
   input wire logic CPU_RUNNING,
   input wire logic UART_IRQ_N,
   input wire logic WAKE_UP,
   input wire logic XFER_RUN,
   input wire logic NINE_BIT_SELECT,
   input wire logic TWO_STOP,
   input wire logic [URX_BAUD_BITS-1:0] BAUD_DIVISOR
);
   // ----------------
   // properties
   // ----------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // a completed write may legally move the controls
   wire logic wr_done = PSEL && PENABLE && PWRITE && PREADY;
   property p_irq_pulse; !UART_IRQ_N |=> UART_IRQ_N; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq low too long");
   property p_xfer_off; CLK_OFF |=> !XFER_RUN; endproperty
   a_xfer_off: assert property (p_xfer_off) else $error("no pause");
   property p_xfer_on; !SYS_RST && !CLK_OFF |=> XFER_RUN; endproperty
   a_xfer_on: assert property (p_xfer_on) else $error("no resume");
   property p_ctrl_hold; CLK_OFF && !wr_done |=> $stable(BAUD_DIVISOR) && $stable(TWO_STOP)
      && $stable(NINE_BIT_SELECT); endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved");
   property p_wake_pulse; WAKE_UP |=> !WAKE_UP; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
   property p_wake_cause; WAKE_UP |-> $past(CLK_OFF) && !$past(RX_PIN); endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake no cause");
   property p_sleep_quiet; CLK_OFF && !CPU_RUNNING |=> UART_IRQ_N; endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("irq in sleep");
   property p_ready; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
   a_ready: assert property (p_ready) else $error("bad ready");
endmodule
bind urx_core urx_monitor urx_monitor_inst (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PREADY,
   .RX_PIN, .CLK_OFF, .CPU_RUNNING, .UART_IRQ_N, .WAKE_UP, .XFER_RUN, .NINE_BIT_SELECT,
   .TWO_STOP, .BAUD_DIVISOR);
`default_nettype wire

// File: tb/urx_far_uart.sv
// far side: remote uart as whole frames plus rx line
// assumes tasks are called from the bench after reset
`timescale 1ns/10ps
`default_nettype none
module urx_far_uart
   import urx_pkg::*;
(
   input wire logic CLK,
   output logic FRAME_DONE,
   output urx_frame_t FRAME,
   output logic RX_PIN
);
   initial begin
      FRAME_DONE = 1'b0;
      FRAME = '0;
      RX_PIN = 1'b1;
   end
   // frame scrambled after use so stale fields never match
   task send(input urx_frame_t f);
      @(posedge CLK);
      FRAME_DONE <= 1'b1;
      FRAME <= f;
      @(posedge CLK);
      FRAME_DONE <= 1'b0;
      FRAME <= ~f;
   endtask
   task start_bit();
      @(posedge CLK);
      RX_PIN <= 1'b0;
      repeat (4) @(posedge CLK);
      RX_PIN <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: tb/tb_urx_core.sv
// self-checking bench for urx_core
// assumes urx_far_uart on the frame side
`timescale 1ns/10ps
`default_nettype none
module tb_urx_core import urx_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, irq_n, wake, xrun, nine, two, frame_done, rx_pin;
   logic [URX_BAUD_BITS-1:0] baud;
   urx_frame_t frame;
   logic tx_empty = 1'b0;
   logic tx_idle = 1'b0;
   logic clk_off = 1'b0;
   logic cpu_run = 1'b1;
   logic gie = 1'b1;
   logic uie = 1'b1;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   int irq_cnt = 0;
   int wake_cnt = 0;
   int w0;
   always #4 clk = ~clk;
   urx_core urx_core_inst (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .FRAME_DONE(frame_done), .FRAME(frame), .TX_EMPTY(tx_empty),
      .TX_IDLE(tx_idle), .RX_PIN(rx_pin), .CLK_OFF(clk_off), .CPU_RUNNING(cpu_run),
      .GLOBAL_IRQ_ENABLE(gie), .UART_IRQ_ENABLE(uie), .UART_IRQ_N(irq_n), .WAKE_UP(wake),
      .XFER_RUN(xrun), .NINE_BIT_SELECT(nine), .TWO_STOP(two), .BAUD_DIVISOR(baud));
   urx_far_uart urx_far_uart_inst (.CLK(clk), .FRAME_DONE(frame_done), .FRAME(frame),
      .RX_PIN(rx_pin));
   // ----------------
   // tasks
   // ----------------
   task close_out();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
      if (cycles == 5000) begin
         error_cnt = error_cnt + 1;
         close_out();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      chk(rd, e);
   endtask
   // count irq pulses over a window wide enough for edge detectors
   task irq_chk(input int exp);
      int n0;
      n0 = irq_cnt;
      repeat (6) @(posedge clk);
      chk(irq_cnt - n0, exp);
   endtask
   task fsend(input logic [8:0] b, input logic p, input logic s1, input logic s2,
      input logic nz);
      urx_far_uart_inst.send('{bits: b, parity_bit: p, stop_one: s1, stop_two: s2, noise: nz});
   endtask
   task doze();
      @(posedge clk);
      clk_off <= 1'b1;
      cpu_run <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'b0, xrun}, 0);
      urx_far_uart_inst.start_bit();
      fsend(9'h033, 0, 1, 1, 0);
      @(posedge clk);
      clk_off <= 1'b0;
      cpu_run <= 1'b1;
   endtask
   // ----------------
   // sequence
   // ----------------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdc(URX_ADDR_STATUS, 0);
      wr(URX_ADDR_STATUS, 32'h0000_007F);
      rdc(URX_ADDR_STATUS, 0);
      apb(1'b0, 12'h0040, '0);
      chk({31'b0, er}, 1);
      wr(URX_ADDR_BAUD, 32'h0000_005A);
      wr(URX_ADDR_CTRL_ONE, 32'h0000_0030);
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0001);
      rdc(URX_ADDR_DATA, 0);
      fsend(9'h055, 0, 1, 1, 1);
      irq_chk(1);
      fsend(9'h0AA, 0, 0, 1, 0);
      irq_chk(1);
      fsend(9'h0FF, 0, 1, 1, 0);
      irq_chk(1);
      rdc(URX_ADDR_DATA, 32'h0000_0055);
      rdc(URX_ADDR_STATUS, 32'h0000_000F);
      rdc(URX_ADDR_DATA, 32'h0000_00AA);
      rdc(URX_ADDR_STATUS, 0);
      wr(URX_ADDR_CTRL_ONE, 32'h0000_0032);
      fsend(9'h001, 0, 1, 1, 0);
      rdc(URX_ADDR_STATUS, 32'h0000_0011);
      rdc(URX_ADDR_DATA, 32'h0000_0001);
      wr(URX_ADDR_CTRL_ONE, 32'h0000_0036);
      fsend(9'h001, 0, 1, 1, 0);
      rdc(URX_ADDR_STATUS, 32'h0000_0001);
      rdc(URX_ADDR_DATA, 32'h0000_0001);
      wr(URX_ADDR_CTRL_ONE, 32'h0000_0038);
      fsend(9'h002, 0, 1, 0, 0);
      chk({31'b0, two}, 1);
      rdc(URX_ADDR_STATUS, 32'h0000_0009);
      rdc(URX_ADDR_DATA, 32'h0000_0002);
      wr(URX_ADDR_CTRL_ONE, 32'h0000_0030);
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0009);
      fsend(9'h07F, 0, 1, 1, 0);
      irq_chk(0);
      fsend(9'h080, 0, 1, 1, 0);
      irq_chk(1);
      rdc(URX_ADDR_DATA, 32'h0000_007F);
      rdc(URX_ADDR_DATA, 32'h0000_0080);
      wr(URX_ADDR_CTRL_ONE, 32'h0000_0031);
      repeat (2) @(posedge clk);
      chk({31'b0, nine}, 1);
      fsend(9'h0FF, 0, 1, 1, 0);
      irq_chk(0);
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0008);
      fsend(9'h100, 0, 1, 1, 0);
      irq_chk(1);
      rdc(URX_ADDR_DATA, 32'h0000_00FF);
      rdc(URX_ADDR_DATA, 32'h0000_0100);
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0000);
      fsend(9'h100, 0, 1, 1, 0);
      irq_chk(0);
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0001);
      fsend(9'h000, 0, 1, 1, 0);
      irq_chk(1);
      rdc(URX_ADDR_DATA, 32'h0000_0100);
      rdc(URX_ADDR_DATA, 0);
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0002);
      @(posedge clk);
      tx_empty <= 1'b1;
      irq_chk(1);
      tx_idle <= 1'b1;
      irq_chk(0);
      rdc(URX_ADDR_STATUS, 32'h0000_0060);
      tx_empty <= 1'b0;
      tx_idle <= 1'b0;
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0011);
      w0 = wake_cnt;
      doze();
      irq_chk(1);
      chk(wake_cnt - w0, 1);
      rdc(URX_ADDR_STATUS, 0);
      rdc(URX_ADDR_BAUD, 32'h0000_005A);
      chk({24'b0, baud}, 32'h0000_005A);
      rdc(URX_ADDR_CTRL_TWO, 32'h0000_0011);
      gie <= 1'b0;
      doze();
      irq_chk(0);
      chk(wake_cnt - w0, 2);
      gie <= 1'b1;
      uie <= 1'b0;
      doze();
      irq_chk(0);
      chk(wake_cnt - w0, 3);
      uie <= 1'b1;
      wr(URX_ADDR_CTRL_TWO, 32'h0000_0001);
      doze();
      irq_chk(0);
      chk(wake_cnt - w0, 3);
      close_out();
   end
endmodule
`default_nettype wire
